/* pkg/mle_pkg.sv */
/*
 * Shared types and constants for the move/logic/rotate execution datapath.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
package mle_pkg;

    localparam int          MLE_DATA_W    = 8;
    localparam int          MLE_ADDR_W    = 8;
    localparam int          MLE_PC_W      = 12;
    localparam int          MLE_STACK_D   = 6;
    localparam logic [7:0]  MLE_ACC_RST   = 8'h00;
    localparam logic [7:0]  MLE_ZERO      = 8'h00;
    localparam logic [7:0]  MLE_ONE       = 8'h01;
    localparam logic [1:0]  MLE_RET_CYC   = 2'h2;
    localparam logic [1:0]  MLE_SKIP_CYC  = 2'h2;
    localparam logic [1:0]  MLE_PLAIN_CYC = 2'h1;
    localparam int          MLE_BIT_MSB   = 7;
    localparam int          MLE_BIT_LSB   = 0;
    localparam int          MLE_NIB_MSB   = 3;

    typedef enum logic [4:0] {
        MLE_OP_NOP,
        MLE_OP_MOV_AM,
        MLE_OP_MOV_AX,
        MLE_OP_MOV_MA,
        MLE_OP_OR_AM,
        MLE_OP_OR_AX,
        MLE_OP_ORM,
        MLE_OP_RET,
        MLE_OP_RET_AX,
        MLE_OP_INTERRUPT_RETURN_OP,
        MLE_OP_RL,
        MLE_OP_RLA,
        MLE_OP_RLC,
        MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP,
        MLE_OP_RR,
        MLE_OP_RRA,
        MLE_OP_RRC,
        MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP,
        MLE_OP_SBC,
        MLE_OP_SUBTRACT_BORROW_TO_MEM_OP,
        MLE_OP_SDZ,
        MLE_OP_DECREMENT_SKIP_ZERO_TO_ACC_OP
    } mle_op_t;

    typedef struct packed {
        logic [MLE_PC_W-1:0] pc;
        logic                stack_empty;
    } mle_stack_t;

    typedef struct packed {
        logic       valid;
        mle_op_t    op;
        logic [7:0] addr;
        logic [7:0] imm;
    } mle_instr_t;

    typedef struct packed {
        logic       carry;
        logic       half_carry;
        logic       zero;
        logic       overflow;
    } mle_flags_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mle_mem_wr_t;

    typedef enum logic [1:0] {
        MLE_ST_EXEC,
        MLE_ST_DUMMY
    } mle_state_t;

endpackage

/* verilog/mle_stack.sv */
/*
 * Return stack holding program counter values.
 * Assumes the caller never pushes when full or pops when empty; such
 * requests are ignored. Top of stack comes out of a register.
 */
module mle_stack
    import mle_pkg::*;
#(
    parameter int DEPTH = MLE_STACK_D,
    parameter int PC_W  = MLE_PC_W
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_pc,
    input  wire logic            pop,
    output logic      [PC_W-1:0] top_pc,
    output logic                 empty
);

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] mem;
        logic [3:0]                 cnt;
        logic [PC_W-1:0]            top;
    } mle_stk_state_t;

    mle_stk_state_t s_r;
    mle_stk_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (push && (s_r.cnt < 4'(DEPTH))) begin
            s_nxt.mem[s_r.cnt[2:0]] = push_pc;
            s_nxt.cnt = s_r.cnt + 4'h1;
            s_nxt.top = push_pc;
        end else if (pop && (s_r.cnt != 4'h0)) begin
            s_nxt.cnt = s_r.cnt - 4'h1;
            // Top after pop is the entry below; read out registered
            if (s_r.cnt > 4'h1) begin
                s_nxt.top = s_r.mem[3'(s_r.cnt - 4'h2)];
            end else begin
                s_nxt.top = '0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign top_pc = s_r.top;
    assign empty  = (s_r.cnt == 4'h0);

endmodule

/* verilog/mle_exec.sv */
/*
 * Execution datapath for moves, OR, returns, rotates, subtract with
 * borrow and decrement-and-skip of an 8-bit microcontroller.
 * Assumes the instruction arrives with its memory operand already read
 * (mem_rdata) in the same cycle; memory writes leave as a registered
 * strobe. Program-counter sequencing outside this block follows pc_load
 * and discard pulses.
 */
// What this block does
// - Memory to accumulator move, flags kept
// - Immediate byte loads accumulator, flags kept
// - Accumulator written to memory, flags kept
// - No-op only advances program counter
// - OR with memory or immediate, zero only
// - Return pops PC, two cycles
// - Return with immediate loads it into accumulator
// - Interrupt return pops PC, enables interrupts
// - Rotate left, bit 7 into bit 0
// - Rotate left through carry, carry only
// - Rotate right, bit 0 into bit 7
// - Rotate right through carry, carry only
// - Accumulator rotates leave memory untouched
// - Subtract borrow: acc plus not m plus carry
// - Memory form writes difference to memory
// - Decrement memory, skip on zero, two cycles when skipping
// - Accumulator decrement-skip leaves memory alone
module mle_exec
    import mle_pkg::*;
#(
    parameter int PC_W        = MLE_PC_W,
    parameter int STACK_DEPTH = MLE_STACK_D
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire mle_instr_t       instr,
    input  wire logic [7:0]       mem_rdata,
    input  wire logic [PC_W-1:0]  pc_in,
    input  wire logic             call_push,
    input  wire logic             gie_clear,
    output mle_mem_wr_t           mem_wr,
    output logic [7:0]            accumulator_reg,
    output mle_flags_t            flags,
    output logic                  global_interrupt_enable,
    output logic [PC_W-1:0]       pc_out,
    output logic                  pc_load,
    output logic                  pc_advance,
    output logic                  discard_next,
    output logic                  busy
);

    typedef struct packed {
        mle_state_t      st;
        logic [7:0]      acc;
        mle_flags_t      fl;
        logic            gie;
        mle_mem_wr_t     wr;
        logic [PC_W-1:0] pc;
        logic            pc_ld;
        logic            pc_adv;
        logic            discard;
        logic            busy;
        logic            pend_pc;
    } mle_exec_state_t;

    mle_exec_state_t s_r;
    mle_exec_state_t s_nxt;

    logic            stk_pop;
    logic [PC_W-1:0] stk_top;
    logic            stk_empty;

    logic [8:0]      sbc_sum;
    logic [4:0]      sbc_low;
    logic [7:0]      m_n;
    logic [7:0]      dec_val;
    logic [7:0]      or_val;
    logic [7:0]      res;
    logic            upd_z;

    mle_stack #(
        .DEPTH (STACK_DEPTH),
        .PC_W  (PC_W)
    ) u_stack (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .push    (call_push),
        .push_pc (pc_in),
        .pop     (stk_pop),
        .top_pc  (stk_top),
        .empty   (stk_empty)
    );

    // Pop in the first return cycle; the popped top is registered and
    // used in the second cycle, which is why returns take two cycles.
    always_comb begin
        stk_pop = 1'b0;
        if (s_r.st == MLE_ST_EXEC && instr.valid) begin
            case (instr.op)
                MLE_OP_RET, MLE_OP_RET_AX, MLE_OP_INTERRUPT_RETURN_OP: stk_pop = 1'b1;
                default: stk_pop = 1'b0;
            endcase
        end
    end

    always_comb begin
        m_n     = ~mem_rdata;
        sbc_sum = {1'b0, s_r.acc} + {1'b0, m_n} + {8'h00, s_r.fl.carry};
        // Half carry is the carry out of bit 3 of the same sum
        sbc_low = {1'b0, s_r.acc[MLE_NIB_MSB:0]} + {1'b0, m_n[3:0]}
                + {4'h0, s_r.fl.carry};
        dec_val = mem_rdata - MLE_ONE;
        or_val  = s_r.acc | (instr.op == MLE_OP_OR_AX ? instr.imm
                                                       : mem_rdata);
    end

    always_comb begin
        s_nxt         = s_r;
        s_nxt.wr.we   = 1'b0;
        s_nxt.pc_ld   = 1'b0;
        s_nxt.pc_adv  = 1'b0;
        s_nxt.discard = 1'b0;
        res           = MLE_ZERO;
        upd_z         = 1'b0;
        // Interrupt entry clears the enable; a return from interrupt in
        // the same cycle sets it again further down and so wins
        if (gie_clear) begin
            s_nxt.gie = 1'b0;
        end
        case (s_r.st)
            MLE_ST_DUMMY: begin
                // Dummy cycle for a skip or second cycle of a return
                s_nxt.st   = MLE_ST_EXEC;
                s_nxt.busy = 1'b0;
                // Return address was latched in the first cycle
                if (s_r.pend_pc) begin
                    s_nxt.pc_ld   = 1'b1;
                    s_nxt.pend_pc = 1'b0;
                end
            end
            MLE_ST_EXEC: begin
                if (instr.valid) begin
                    s_nxt.pc_adv = 1'b1;
                    s_nxt.wr.addr = instr.addr;
                    case (instr.op)
                        MLE_OP_NOP: begin
                            s_nxt.pc_adv = 1'b1;
                        end
                        MLE_OP_MOV_AM: s_nxt.acc = mem_rdata;
                        MLE_OP_MOV_AX: s_nxt.acc = instr.imm;
                        MLE_OP_MOV_MA: begin
                            s_nxt.wr.we    = 1'b1;
                            s_nxt.wr.wdata = s_r.acc;
                        end
                        MLE_OP_OR_AM, MLE_OP_OR_AX: begin
                            res       = or_val;
                            s_nxt.acc = res;
                            upd_z     = 1'b1;
                        end
                        MLE_OP_ORM: begin
                            res            = s_r.acc | mem_rdata;
                            s_nxt.wr.we    = 1'b1;
                            s_nxt.wr.wdata = res;
                            upd_z          = 1'b1;
                        end
                        MLE_OP_RET, MLE_OP_RET_AX, MLE_OP_INTERRUPT_RETURN_OP: begin
                            s_nxt.st      = MLE_ST_DUMMY;
                            s_nxt.busy    = 1'b1;
                            s_nxt.pend_pc = 1'b1;
                            s_nxt.pc_adv  = 1'b0;
                            // Latch the return address now: the pop
                            // moves the stack top before the second
                            // cycle. An empty stack returns to zero and
                            // the underflow is not reported.
                            s_nxt.pc      = stk_empty ? '0 : stk_top;
                            if (instr.op == MLE_OP_RET_AX) begin
                                s_nxt.acc = instr.imm;
                            end
                            if (instr.op == MLE_OP_INTERRUPT_RETURN_OP) begin
                                s_nxt.gie = 1'b1;
                            end
                        end
                        MLE_OP_RL, MLE_OP_RLA: begin
                            res = {mem_rdata[6:0],
                                   mem_rdata[MLE_BIT_MSB]};
                        end
                        MLE_OP_RLC, MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP: begin
                            res = {mem_rdata[6:0], s_r.fl.carry};
                            s_nxt.fl.carry = mem_rdata[MLE_BIT_MSB];
                        end
                        MLE_OP_RR, MLE_OP_RRA: begin
                            res = {mem_rdata[MLE_BIT_LSB],
                                   mem_rdata[7:1]};
                        end
                        MLE_OP_RRC, MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP: begin
                            res = {s_r.fl.carry, mem_rdata[7:1]};
                            s_nxt.fl.carry = mem_rdata[MLE_BIT_LSB];
                        end
                        MLE_OP_SBC, MLE_OP_SUBTRACT_BORROW_TO_MEM_OP: begin
                            res = sbc_sum[7:0];
                            s_nxt.fl.carry      = sbc_sum[8];
                            s_nxt.fl.half_carry = sbc_low[4];
                            s_nxt.fl.overflow   =
                                (s_r.acc[7] == m_n[7]) &&
                                (res[7] != s_r.acc[7]);
                            upd_z = 1'b1;
                        end
                        MLE_OP_SDZ, MLE_OP_DECREMENT_SKIP_ZERO_TO_ACC_OP: begin
                            // Flags untouched; only the skip reacts to
                            // a zero result
                            res = dec_val;
                            if (dec_val == MLE_ZERO) begin
                                s_nxt.st      = MLE_ST_DUMMY;
                                s_nxt.busy    = 1'b1;
                                s_nxt.discard = 1'b1;
                            end
                        end
                        default: s_nxt.pc_adv = 1'b1;
                    endcase
                    // Destination selection for the rotate/arith group
                    case (instr.op)
                        MLE_OP_RL, MLE_OP_RLC, MLE_OP_RR, MLE_OP_RRC,
                        MLE_OP_SDZ, MLE_OP_SUBTRACT_BORROW_TO_MEM_OP: begin
                            s_nxt.wr.we    = 1'b1;
                            s_nxt.wr.wdata = res;
                        end
                        MLE_OP_RLA, MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP, MLE_OP_RRA, MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP,
                        MLE_OP_DECREMENT_SKIP_ZERO_TO_ACC_OP, MLE_OP_SBC: begin
                            s_nxt.acc = res;
                        end
                        default: begin
                        end
                    endcase
                    if (upd_z) begin
                        s_nxt.fl.zero = (res == MLE_ZERO);
                    end
                end
            end
            default: s_nxt.st = MLE_ST_EXEC;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r     <= '0;
            s_r.acc <= MLE_ACC_RST;
            s_r.st  <= MLE_ST_EXEC;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign mem_wr                  = s_r.wr;
    assign accumulator_reg         = s_r.acc;
    assign flags                   = s_r.fl;
    assign global_interrupt_enable = s_r.gie;
    assign pc_out                  = s_r.pc;
    assign pc_load                 = s_r.pc_ld;
    assign pc_advance              = s_r.pc_adv;
    assign discard_next            = s_r.discard;
    assign busy                    = s_r.busy;

endmodule

/* verif/mle_exec_props.sv */
/*
 * Port-level checker for the execution datapath.
 * Assumes ce stays high whenever an instruction is in flight.
 */
module mle_exec_props
    import mle_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce,
    input wire mle_instr_t  instr,
    input wire logic [7:0]  mem_rdata,
    input wire mle_mem_wr_t mem_wr,
    input wire logic [7:0]  accumulator_reg,
    input wire mle_flags_t  flags,
    input wire logic        global_interrupt_enable,
    input wire logic        pc_load,
    input wire logic        pc_advance,
    input wire logic        discard_next,
    input wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    assign tk = ce && instr.valid && !busy;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_mov_mem_acc: assert property (tk && instr.op == MLE_OP_MOV_AM |=>
        accumulator_reg == $past(mem_rdata) && $stable(flags))
        else $error("memory to accumulator move wrong");
    a_mov_imm_acc: assert property (tk && instr.op == MLE_OP_MOV_AX |=>
        accumulator_reg == $past(instr.imm) && $stable(flags))
        else $error("immediate load wrong");
    a_mov_to_mem: assert property (tk && instr.op == MLE_OP_MOV_MA |=>
        mem_wr.we && mem_wr.wdata == $past(accumulator_reg)
        && mem_wr.addr == $past(instr.addr) && $stable(flags))
        else $error("accumulator to memory move wrong");
    a_nop_quiet: assert property (tk && instr.op == MLE_OP_NOP |=>
        pc_advance && !mem_wr.we && $stable(accumulator_reg) && $stable(flags))
        else $error("no-op changed state");
    a_ret_two_cyc: assert property (tk && instr.op == MLE_OP_RET |=>
        busy && !pc_load ##1 pc_load && !busy)
        else $error("return timing wrong");
    a_interrupt_return_op_gie: assert property (tk && instr.op == MLE_OP_INTERRUPT_RETURN_OP |=>
        global_interrupt_enable)
        else $error("interrupt return left interrupts off");
    a_rotate_left_carry_to_acc_op_val: assert property (tk && instr.op == MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP |=>
        accumulator_reg == {$past(mem_rdata[6:0]), $past(flags.carry)}
        && flags.carry == $past(mem_rdata[7]) && !mem_wr.we)
        else $error("left rotate through carry wrong");
    a_rotate_right_carry_to_acc_op_val: assert property (tk && instr.op == MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP |=>
        accumulator_reg == {$past(flags.carry), $past(mem_rdata[7:1])}
        && flags.carry == $past(mem_rdata[0]) && !mem_wr.we)
        else $error("right rotate through carry wrong");
    a_sdz_skip: assert property (tk && instr.op == MLE_OP_SDZ |=>
        mem_wr.we && mem_wr.wdata == $past(mem_rdata) - 8'h01
        && discard_next == ($past(mem_rdata) == 8'h01))
        else $error("decrement and skip wrong");
    a_or_zero: assert property (tk && instr.op == MLE_OP_OR_AX |=>
        flags.zero == (accumulator_reg == 8'h00) && !mem_wr.we)
        else $error("OR zero flag wrong");
endmodule

bind mle_exec mle_exec_props u_props (
    .mclk                    (mclk),
    .rst                     (rst),
    .ce                      (ce),
    .instr                   (instr),
    .mem_rdata               (mem_rdata),
    .mem_wr                  (mem_wr),
    .accumulator_reg         (accumulator_reg),
    .flags                   (flags),
    .global_interrupt_enable (global_interrupt_enable),
    .pc_load                 (pc_load),
    .pc_advance              (pc_advance),
    .discard_next            (discard_next),
    .busy                    (busy)
);

/* verif/mle_dmem_model.sv */
/*
 * Data memory partner: combinational read at the instruction address,
 * write on the registered strobe of the datapath.
 */
module mle_dmem_model
    import mle_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [7:0]  addr,
    input  wire mle_mem_wr_t wr,
    output logic      [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    assign rdata = mem[addr];
    always @(posedge mclk) begin
        if (wr.we) begin
            mem[wr.addr] <= wr.wdata;
        end
    end
endmodule

/* verif/test_mcu_move_logic_rotate_exec.sv */
/*
 * Directed bench for mle_exec with the data memory model.
 * Inputs change at the falling edge; at least one idle cycle between instructions.
 */
module test_mcu_move_logic_rotate_exec
    import mle_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, ce, call_push, gie_clear, pc_load, pc_advance;
    logic discard_next, busy, gie, c;
    logic [7:0] rdata, acc, a, m, r;
    logic [11:0] pc_in, pc_out;
    logic [8:0] v;
    mle_instr_t instr;
    mle_mem_wr_t mem_wr;
    mle_flags_t flags;
    int n_errors, num_checks;
    mle_op_t ro [8] = '{MLE_OP_RL, MLE_OP_RLA, MLE_OP_RR, MLE_OP_RRA,
        MLE_OP_RLC, MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP, MLE_OP_RRC, MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP};

    mle_exec u_dut (.mclk(mclk), .rst(rst), .ce(ce), .instr(instr),
        .mem_rdata(rdata), .pc_in(pc_in), .call_push(call_push),
        .gie_clear(gie_clear), .mem_wr(mem_wr), .accumulator_reg(acc),
        .flags(flags), .global_interrupt_enable(gie), .pc_out(pc_out),
        .pc_load(pc_load), .pc_advance(pc_advance),
        .discard_next(discard_next), .busy(busy));
    mle_dmem_model u_mem (.mclk(mclk), .addr(instr.addr), .wr(mem_wr),
        .rdata(rdata));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic results();
        if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic op(mle_op_t o, logic [7:0] ad, logic [7:0] im);
        @(negedge mclk);
        instr <= '{1'b1, o, ad, im};
        @(negedge mclk);
        instr.valid <= 1'b0;
    endtask

    task automatic push(logic [11:0] p);
        @(negedge mclk);
        call_push <= 1'b1;
        pc_in <= p;
        @(negedge mclk);
        call_push <= 1'b0;
    endtask

    // Memory writes land one edge after the strobe is seen
    task automatic memchk(logic [7:0] ad, logic [7:0] e);
        @(negedge mclk);
        chk("mem", {8'h00, e}, {8'h00, u_mem.mem[ad]});
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        results();
    end

    initial begin
        rst = 1'b1; ce = 1'b1; call_push = 1'b0; gie_clear = 1'b0;
        pc_in = 12'h000; instr = '0; c = 1'b0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk("reset", 16'h0000, {acc, 3'h0, gie, flags});
        op(MLE_OP_MOV_AX, 8'h00, 8'h5a); chk("acc", 16'h5a, acc);
        op(MLE_OP_MOV_MA, 8'h10, 8'h00); memchk(8'h10, 8'h5a);
        u_mem.mem[8'h20] = 8'h81;
        op(MLE_OP_MOV_AM, 8'h20, 8'h00); chk("acc", 16'h81, acc);
        op(MLE_OP_NOP, 8'h00, 8'h00); chk("adv", 16'h1, pc_advance);
        chk("acc", 16'h81, acc);
        foreach (ro[i]) begin
            m = 8'h81 ^ 8'(i);
            u_mem.mem[8'h30] = m;
            v = (i < 4) ? {c, 8'h00} : {c, 8'h00};
            case (ro[i])
                MLE_OP_RL, MLE_OP_RLA: v = {c, m[6:0], m[7]};
                MLE_OP_RR, MLE_OP_RRA: v = {c, m[0], m[7:1]};
                MLE_OP_RLC, MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP: v = {m[7], m[6:0], c};
                default: v = {m[0], c, m[7:1]};
            endcase
            a = acc;
            op(ro[i], 8'h30, 8'h00);
            c = v[8];
            chk("carry", {15'h0, v[8]}, {15'h0, flags.carry});
            if (ro[i] inside {MLE_OP_RLA, MLE_OP_RRA, MLE_OP_ROTATE_LEFT_CARRY_TO_ACC_OP,
                    MLE_OP_ROTATE_RIGHT_CARRY_TO_ACC_OP}) begin
                chk("acc", {8'h0, v[7:0]}, acc);
                memchk(8'h30, m);
            end else begin
                chk("acc", {8'h0, a}, acc);
                memchk(8'h30, v[7:0]);
            end
        end
        op(MLE_OP_MOV_AX, 8'h00, 8'h00);
        op(MLE_OP_OR_AX, 8'h00, 8'h00); chk("z", 16'h1, flags.zero);
        u_mem.mem[8'h40] = 8'h0c;
        op(MLE_OP_OR_AM, 8'h40, 8'h00); chk("acc", 16'h0c, acc);
        chk("z", 16'h0, flags.zero);
        u_mem.mem[8'h41] = 8'h30;
        op(MLE_OP_ORM, 8'h41, 8'h00); memchk(8'h41, 8'h3c);
        for (int k = 0; k < 2; k++) begin
            a = acc;
            m = 8'h85 + 8'(k * 8'h44);
            u_mem.mem[8'h50] = m;
            {v} = {1'b0, a} + {1'b0, ~m} + 9'(c);
            r = {4'h0, a[3:0]} + {4'h0, ~m[3:0]} + 8'(c);
            op(k ? MLE_OP_SUBTRACT_BORROW_TO_MEM_OP : MLE_OP_SBC, 8'h50, 8'h00);
            chk("sbc flags", {12'h0, v[8], r[4], v[7:0] == 8'h00,
                a[7] == ~m[7] && v[7] != a[7]}, flags);
            if (k) memchk(8'h50, v[7:0]);
            else chk("acc", {8'h0, v[7:0]}, acc);
            c = v[8];
        end
        u_mem.mem[8'h60] = 8'h01;
        op(MLE_OP_SDZ, 8'h60, 8'h00);
        chk("skip", 16'h11, {busy, 3'h0, discard_next});
        memchk(8'h60, 8'h00);
        u_mem.mem[8'h61] = 8'h05;
        op(MLE_OP_SDZ, 8'h61, 8'h00);
        chk("skip", 16'h00, {busy, 3'h0, discard_next});
        memchk(8'h61, 8'h04);
        op(MLE_OP_DECREMENT_SKIP_ZERO_TO_ACC_OP, 8'h60, 8'h00); chk("acc", 16'hff, acc);
        u_mem.mem[8'h62] = 8'h01;
        op(MLE_OP_DECREMENT_SKIP_ZERO_TO_ACC_OP, 8'h62, 8'h00); chk("acc", 16'h00, acc);
        chk("skip", 16'h1, discard_next);
        memchk(8'h62, 8'h01);
        push(12'h123);
        op(MLE_OP_RET, 8'h00, 8'h00); chk("busy", 16'h1, busy);
        @(negedge mclk);
        chk("ret", 16'h1123, {3'h0, pc_load, pc_out});
        push(12'h0ab);
        op(MLE_OP_RET_AX, 8'h00, 8'h3c); chk("acc", 16'h3c, acc);
        @(negedge mclk);
        chk("ret", 16'h10ab, {3'h0, pc_load, pc_out});
        @(negedge mclk);
        gie_clear <= 1'b1;
        @(negedge mclk);
        gie_clear <= 1'b0;
        push(12'h456);
        op(MLE_OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00); chk("gie", 16'h1, gie);
        @(negedge mclk);
        chk("ret", 16'h1456, {3'h0, pc_load, pc_out});
        gie_clear <= 1'b1;
        @(negedge mclk);
        gie_clear <= 1'b0;
        chk("gie", 16'h0, gie);
        results();
    end
endmodule
